//--- design/eod_device.sv
// eod_device: encoder process-object dictionary, device end of the link
// assumes: single pclk domain; sensor inputs come from logic on pclk
// Functional notes
// - steps per turn rw, stored, alias 2101h
// - total step range rw and stored
// - preset rw, default zero, stored
// - position read-only, alias 2000h
// - 16-bit speed saturates at range limits
// - 32-bit speed offered at 3010h
// - 16-bit acceleration, count reads one
// - cycle timer ms, default 64h, stored
// - cycle timer shared with TPDO1, 2200h
// - cam state channel 1, default 4
// - cam enable channel 1 rw, stored
// - SDO 600h+node, eight bytes, LSB first
// - master sets TPDO2 type to FEh
// - master writes TPDO2 event timer
// - mapping count zeroed before entry change
// - mapping entry holds index, sub, length
// - 16-bit speed output only after enable written
// - save signature to 1010h stores parameters
// - NMT start command enters operational
`timescale 1ns/1ps
`include "eod_defs.svh"
module eod_device
  import eod_pkg::*;
#(
  parameter int CYC_PER_MS = `EOD_MS_NS / `EOD_PCLK_NS
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // link to master
  eod_if.dev                      lnk,
  // node and sensor values
  input  wire logic        [6:0]  node_id,
  input  wire logic        [31:0] position_in,
  input  wire logic signed [31:0] velocity_in,
  input  wire logic        [15:0] accel_in,
  input  wire logic        [7:0]  cam_in,
  // parameters to the sensing logic
  output logic             [31:0] steps_per_turn,
  output logic             [31:0] total_step_range,
  output logic             [31:0] position_preset,
  output logic             [7:0]  cam_enable,
  output logic                    speed_enable,
  output logic                    operational
);
  eod_dev_t    s;
  eod_dev_t    n;
  logic [31:0] st_rdata;

  function automatic logic [32:0] var_obj(logic [7:0] sub,
                                          logic [31:0] v);
    return {sub == `EOD_SUB_CNT, v};
  endfunction : var_obj

  function automatic logic [32:0] arr_obj(logic [7:0] sub,
                                          logic [31:0] v);
    logic [32:0] r;
    r = '0;
    if (sub == `EOD_SUB_CNT) begin
      r = {1'b1, 24'h00_0000, `EOD_MAP_MAX};
    end else if (sub == `EOD_SUB_VAL) begin
      r = {1'b1, v};
    end
    return r;
  endfunction : arr_obj

  // bit 32 flags an existing entry, bits 31:0 its value
  function automatic logic [32:0] rd_obj(eod_dev_t d, logic [15:0] ix,
                                         logic [7:0] sub);
    logic [32:0] r;
    r = '0;
    case (ix)
      `EOD_IX_STEPS, `EOD_IX_RES: r = var_obj(sub, d.steps);
      `EOD_IX_RANGE: r = var_obj(sub, d.range);
      `EOD_IX_PRESET: r = var_obj(sub, d.preset);
      `EOD_IX_POS, `EOD_IX_POSALIAS: r = var_obj(sub, d.pos);
      `EOD_IX_SPEED: r = arr_obj(sub, {{16{d.spd[15]}}, d.spd});
      `EOD_IX_ACCEL: r = arr_obj(sub, {{16{d.acc[15]}}, d.acc});
      `EOD_IX_CYCLE, `EOD_IX_CYCALIAS:
        r = var_obj(sub, {16'h0000, d.cycle});
      `EOD_IX_CAMST: r = arr_obj(sub, {24'h00_0000, d.camst});
      `EOD_IX_CAMEN: r = arr_obj(sub, {24'h00_0000, d.camen});
      `EOD_IX_SPDCTL: begin
        if (sub == `EOD_SUB_SPD32) begin
          r = {1'b1, d.spd32};
        end else begin
          r = arr_obj(sub, {31'h0000_0000, d.spd_en});
        end
      end
      `EOD_IX_TPDO1: begin
        if (sub == `EOD_SUB_EVT) begin
          r = {1'b1, 16'h0000, d.cycle};
        end
      end
      `EOD_IX_TPDO2: begin
        if (sub == `EOD_SUB_TT) begin
          r = {1'b1, 24'h00_0000, d.tt2};
        end else if (sub == `EOD_SUB_EVT) begin
          r = {1'b1, 16'h0000, d.evt2};
        end
      end
      `EOD_IX_MAP2: begin
        if (sub == `EOD_SUB_CNT) begin
          r = {1'b1, 24'h00_0000, d.map2_cnt};
        end else if (sub == `EOD_SUB_VAL) begin
          r = {1'b1, d.map2_ent};
        end
      end
      default: r = '0;
    endcase
    return r;
  endfunction : rd_obj

  function automatic logic [31:0] store_word(eod_dev_t d, logic [2:0] k);
    logic [31:0] w;
    case (k)
      3'h1:    w = d.steps;
      3'h2:    w = d.range;
      3'h3:    w = d.preset;
      3'h4:    w = {8'h00, d.camen, d.cycle};
      default: w = `EOD_SIG;
    endcase
    return w;
  endfunction : store_word

  function automatic eod_frame_t sdo_rsp(logic [6:0] node, logic [7:0] cmd,
                                         logic [15:0] ix, logic [7:0] sub,
                                         logic [31:0] v);
    eod_frame_t f;
    f.id   = `EOD_ID_SDO_TX + {4'h0, node};
    f.len  = `EOD_SDO_LEN;
    f.data = {v, sub, ix, cmd};
    return f;
  endfunction : sdo_rsp

  eod_store u_store (
    .pclk  (pclk),
    .we    (s.st == EOD_SAVE),
    .addr  (s.widx),
    .wdata (store_word(s, s.widx)),
    .rdata (st_rdata)
  );

  always_comb begin
    logic [32:0] r;
    logic        ok;
    logic [15:0] ix;
    logic [7:0]  sub;
    logic [31:0] val;
    eod_frame_t  f;
    n   = s;
    r   = '0;
    ok  = 1'b0;
    f   = lnk.m2d_frame;
    ix  = f.data[23:8];
    sub = f.data[31:24];
    val = f.data[63:32];
    n.txv   = 1'b0;
    n.pos   = position_in;
    n.acc   = accel_in;
    n.spd32 = velocity_in;
    // speed stays zero until the master enables it
    if (!s.spd_en) begin
      n.spd = 16'h0000;
    end else if (velocity_in > `EOD_SPD_MAX) begin
      n.spd = 16'h7FFF;
    end else if (velocity_in < `EOD_SPD_MIN) begin
      n.spd = 16'h8000;
    end else begin
      n.spd = velocity_in[15:0];
    end
    n.camst = s.camen[0] ? cam_in : `EOD_CAMST_RST;
    // sends first, so a pending flag set below is never lost
    if (s.st == EOD_RUN && s.rsp_pend) begin
      n.tx = s.rsp;
      n.txv = 1'b1;
      n.rsp_pend = 1'b0;
    end else if (s.t1_pend) begin
      n.tx.id = `EOD_ID_TPDO1 + {4'h0, node_id};
      n.tx.len = `EOD_TPDO1_LEN;
      n.tx.data = {32'h0000_0000, s.pos};
      n.txv = 1'b1;
      n.t1_pend = 1'b0;
    end else if (s.t2_pend) begin
      r = rd_obj(s, s.map2_ent[31:16], s.map2_ent[15:8]);
      n.tx.id = `EOD_ID_TPDO2 + {4'h0, node_id};
      n.tx.len = s.map2_ent[6:3];
      n.tx.data = {32'h0000_0000,
                   r[31:0] & ~(32'hFFFF_FFFF << s.map2_ent[5:0])};
      n.txv = 1'b1;
      n.t2_pend = 1'b0;
    end
    n.tick = (s.tick == 32'(CYC_PER_MS - 1)) ? '0 : s.tick + 32'h1;
    if (s.oper && s.tick == 32'(CYC_PER_MS - 1)) begin
      n.ms1 = s.ms1 + 16'h1;
      if (n.ms1 >= s.cycle) begin
        n.ms1 = '0;
        n.t1_pend = 1'b1;
      end
      if (s.tt2 == `EOD_TT_EVENT && s.evt2 != 16'h0000 &&
          s.map2_cnt == `EOD_MAP_MAX) begin
        n.ms2 = s.ms2 + 16'h1;
        if (n.ms2 >= s.evt2) begin
          n.ms2 = '0;
          n.t2_pend = 1'b1;
        end
      end
    end
    unique case (s.st)
      EOD_LOAD: begin
        if (s.widx == 3'h0) begin
          n.nvok = (st_rdata == `EOD_SIG);
        end else if (s.nvok) begin
          case (s.widx)
            3'h1:    n.steps = st_rdata;
            3'h2:    n.range = st_rdata;
            3'h3:    n.preset = st_rdata;
            default: {n.camen, n.cycle} = st_rdata[23:0];
          endcase
        end
        if (s.widx == `EOD_ST_LAST) begin
          n.st = EOD_RUN;
        end else begin
          n.widx = s.widx + 3'h1;
        end
      end
      // marker word goes last so a cut-short first save is never trusted
      EOD_SAVE: begin
        if (s.widx == 3'h0) begin
          n.st = EOD_RUN;
        end else begin
          n.widx = (s.widx == `EOD_ST_LAST) ? 3'h0 : s.widx + 3'h1;
        end
      end
      EOD_RUN: begin
        if (lnk.m2d_valid && s.rdy) begin
          if (f.id == `EOD_ID_NMT && f.len == `EOD_NMT_LEN &&
              (f.data[15:8] == `EOD_NMT_ALL ||
               f.data[15:8] == {1'b0, node_id})) begin
            if (f.data[7:0] == `EOD_NMT_START) begin
              n.oper = 1'b1;
            end else if (f.data[7:0] == `EOD_NMT_PREOP) begin
              n.oper = 1'b0;
            end
          end else if (f.id == `EOD_ID_SDO_RX + {4'h0, node_id} &&
                       f.len == `EOD_SDO_LEN) begin
            if (f.data[7:0] == `EOD_SDO_WR) begin
              ok = 1'b1;
              case (ix)
                `EOD_IX_STEPS, `EOD_IX_RES: n.steps = val;
                `EOD_IX_RANGE: n.range = val;
                `EOD_IX_PRESET: n.preset = val;
                `EOD_IX_CYCLE, `EOD_IX_CYCALIAS: begin
                  ok = (val[15:0] != 16'h0000);
                  if (ok) n.cycle = val[15:0];
                end
                `EOD_IX_TPDO1: begin
                  ok = (sub == `EOD_SUB_EVT && val[15:0] != 16'h0000);
                  if (ok) n.cycle = val[15:0];
                end
                `EOD_IX_TPDO2: begin
                  if (sub == `EOD_SUB_TT) begin
                    n.tt2 = val[7:0];
                  end else if (sub == `EOD_SUB_EVT) begin
                    n.evt2 = val[15:0];
                  end else begin
                    ok = 1'b0;
                  end
                end
                `EOD_IX_MAP2: begin
                  if (sub == `EOD_SUB_CNT && val[7:0] <= `EOD_MAP_MAX) begin
                    n.map2_cnt = val[7:0];
                  end else if (sub == `EOD_SUB_VAL &&
                               s.map2_cnt == 8'h00) begin
                    n.map2_ent = val;
                  end else begin
                    ok = 1'b0;
                  end
                end
                `EOD_IX_CAMEN: begin
                  ok = (sub == `EOD_SUB_VAL);
                  if (ok) n.camen = val[7:0];
                end
                `EOD_IX_SPDCTL: begin
                  ok = (sub == `EOD_SUB_VAL);
                  if (ok) n.spd_en = val[0];
                end
                `EOD_IX_STORE: begin
                  ok = (sub == `EOD_SUB_VAL && val == `EOD_SIG);
                  if (ok) begin
                    n.st = EOD_SAVE;
                    n.widx = 3'h1;
                  end
                end
                default: ok = 1'b0;
              endcase
              n.rsp = sdo_rsp(node_id,
                              ok ? `EOD_SDO_WR_ACK : `EOD_SDO_ABORT, ix,
                              sub, ok ? 32'h0000_0000 : `EOD_ABORT_CODE);
            end else begin
              r = rd_obj(s, ix, sub);
              ok = r[32] && f.data[7:0] == `EOD_SDO_RD;
              n.rsp = sdo_rsp(node_id,
                              ok ? `EOD_SDO_RD_RSP : `EOD_SDO_ABORT, ix,
                              sub, ok ? r[31:0] : `EOD_ABORT_CODE);
            end
            n.rsp_pend = 1'b1;
          end
        end
      end
    endcase
    n.rdy = (n.st == EOD_RUN) && !n.rsp_pend;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s        <= '0;
      s.st     <= EOD_LOAD;
      s.steps  <= `EOD_STEPS_RST;
      s.range  <= `EOD_RANGE_RST;
      s.preset <= `EOD_PRESET_RST;
      s.cycle  <= `EOD_CYCLE_RST;
      s.camst  <= `EOD_CAMST_RST;
      s.camen  <= `EOD_CAMEN_RST;
    end else begin
      s <= n;
    end
  end

  assign lnk.m2d_ready   = s.rdy;
  assign lnk.d2m_valid   = s.txv;
  assign lnk.d2m_frame   = s.tx;
  assign steps_per_turn   = s.steps;
  assign total_step_range = s.range;
  assign position_preset  = s.preset;
  assign cam_enable       = s.camen;
  assign speed_enable     = s.spd_en;
  assign operational      = s.oper;
endmodule : eod_device

//--- design/eod_defs.svh
// eod_defs: object indices, link identifiers, defaults and host offsets
// assumes: included by bare name from every design file that needs it
`ifndef EOD_DEFS_SVH
`define EOD_DEFS_SVH
`define EOD_IX_STEPS     16'h6001
`define EOD_IX_RANGE     16'h6002
`define EOD_IX_PRESET    16'h6003
`define EOD_IX_POS       16'h6004
`define EOD_IX_SPEED     16'h6030
`define EOD_IX_ACCEL     16'h6040
`define EOD_IX_CYCLE     16'h6200
`define EOD_IX_CAMST     16'h6300
`define EOD_IX_CAMEN     16'h6301
`define EOD_IX_RES       16'h2101
`define EOD_IX_POSALIAS  16'h2000
`define EOD_IX_CYCALIAS  16'h2200
`define EOD_IX_SPDCTL    16'h3010
`define EOD_IX_TPDO1     16'h1800
`define EOD_IX_TPDO2     16'h1801
`define EOD_IX_MAP2      16'h1A01
`define EOD_IX_STORE     16'h1010
`define EOD_SUB_CNT      8'h00
`define EOD_SUB_VAL      8'h01
`define EOD_SUB_TT       8'h02
`define EOD_SUB_SPD32    8'h02
`define EOD_SUB_EVT      8'h05
`define EOD_ID_NMT       11'h000
`define EOD_ID_TPDO1     11'h180
`define EOD_ID_TPDO2     11'h280
`define EOD_ID_SDO_TX    11'h580
`define EOD_ID_SDO_RX    11'h600
`define EOD_SDO_LEN      4'h8
`define EOD_NMT_LEN      4'h2
`define EOD_TPDO1_LEN    4'h4
`define EOD_SDO_WR       8'h22
`define EOD_SDO_RD       8'h40
`define EOD_SDO_WR_ACK   8'h60
`define EOD_SDO_RD_RSP   8'h43
`define EOD_SDO_ABORT    8'h80
`define EOD_ABORT_CODE   32'h0602_0000
`define EOD_NMT_START    8'h01
`define EOD_NMT_PREOP    8'h80
`define EOD_NMT_ALL      8'h00
`define EOD_TT_EVENT     8'hFE
`define EOD_MAP_MAX      8'h01
`define EOD_MAPLEN_16    8'h10
`define EOD_EVT2_MS      32'h0000_0064
`define EOD_SIG          32'h6576_6173
`define EOD_STEPS_RST    32'h0001_0000
`define EOD_RANGE_RST    32'h4000_0000
`define EOD_PRESET_RST   32'h0000_0000
`define EOD_CYCLE_RST    16'h0064
`define EOD_CAMST_RST    8'h04
`define EOD_CAMEN_RST    8'h00
`define EOD_SPD_MAX      32'sh0000_7FFF
`define EOD_SPD_MIN      32'shFFFF_8000
`define EOD_ST_LAST      3'h4
`define EOD_MS_NS        1000000
`define EOD_PCLK_NS      8
`define EOD_HR_CTRL      8'h00
`define EOD_HR_TXID      8'h04
`define EOD_HR_TXLEN     8'h08
`define EOD_HR_TXLO      8'h0C
`define EOD_HR_TXHI      8'h10
`define EOD_HR_RXID      8'h14
`define EOD_HR_RXLO      8'h18
`define EOD_HR_RXHI      8'h1C
`define EOD_HR_STAT      8'h20
`define EOD_HR_NODE      8'h24
`define EOD_SEQ_LAST     4'h7
`endif

//--- design/eod_pkg.sv
// eod_pkg: frame, state and register-set types shared by both ends
// assumes: nothing beyond the synthesiser's packed-struct support
package eod_pkg;
  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  len;
    logic [63:0] data;
  } eod_frame_t;

  typedef enum logic [2:0] {
    EOD_LOAD = 3'b001,
    EOD_RUN  = 3'b010,
    EOD_SAVE = 3'b100
  } eod_dst_t;

  typedef enum logic [1:0] {
    EOD_HIDLE = 2'b01,
    EOD_HSEQ  = 2'b10
  } eod_hst_t;

  typedef struct packed {
    eod_dst_t    st;
    logic [2:0]  widx;
    logic        nvok;
    logic [31:0] steps, range, preset, pos, spd32, tick;
    logic [15:0] cycle, spd, acc, evt2, ms1, ms2;
    logic [7:0]  camen, camst, tt2, map2_cnt;
    logic [31:0] map2_ent;
    logic        spd_en, oper, t1_pend, t2_pend, rsp_pend, txv, rdy;
    eod_frame_t  rsp, tx;
  } eod_dev_t;

  typedef struct packed {
    eod_hst_t    st;
    logic [3:0]  step;
    logic [6:0]  node;
    eod_frame_t  txf, rxf;
    logic        txv;
    logic [15:0] rxcnt;
    logic [31:0] prdata;
    logic        pready, pslverr;
  } eod_host_t;
endpackage : eod_pkg

//--- design/eod_if.sv
// eod_if: frame link between the encoder dictionary and its master
// assumes: both ends on pclk; master-to-device frames use valid/ready
`timescale 1ns/1ps
interface eod_if;
  import eod_pkg::*;
  logic       m2d_valid;
  logic       m2d_ready;
  eod_frame_t m2d_frame;
  logic       d2m_valid;
  eod_frame_t d2m_frame;

  modport dev (
    input  m2d_valid, m2d_frame,
    output m2d_ready, d2m_valid, d2m_frame
  );
  modport mst (
    output m2d_valid, m2d_frame,
    input  m2d_ready, d2m_valid, d2m_frame
  );
endinterface : eod_if

//--- design/eod_store.sv
// eod_store: nonvolatile copy of the restorable parameters
// assumes: contents survive presetn, so the array has no reset
`timescale 1ns/1ps
module eod_store #(
  parameter int W     = 32,
  parameter int DEPTH = 5,
  parameter int AW    = 3
) (
  // clock
  input  wire logic          pclk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [W-1:0]  wdata,
  // read side
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // combinational read keeps the restore walk to one word a cycle
  assign rdata = mem[addr];
endmodule : eod_store

//--- design/eod_master.sv
// eod_master: network-master end; APB registers drive the frame link
// assumes: APB on pclk; device may hold m2d_ready low for many cycles
`timescale 1ns/1ps
`include "eod_defs.svh"
module eod_master
  import eod_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link to device
  eod_if.mst               lnk
);
  eod_host_t s;
  eod_host_t n;

  function automatic logic [63:0] sdo(logic [15:0] ix, logic [7:0] sub,
                                      logic [31:0] v);
    return {v, sub, ix, `EOD_SDO_WR};
  endfunction : sdo

  // the fixed speed-into-TPDO2 setup walk
  function automatic eod_frame_t seq_frame(logic [3:0] k, logic [6:0] node);
    eod_frame_t f;
    f.id  = `EOD_ID_SDO_RX + {4'h0, node};
    f.len = `EOD_SDO_LEN;
    case (k)
      4'h0: f.data = sdo(`EOD_IX_TPDO2, `EOD_SUB_TT,
                         {24'h00_0000, `EOD_TT_EVENT});
      4'h1: f.data = sdo(`EOD_IX_TPDO2, `EOD_SUB_EVT, `EOD_EVT2_MS);
      4'h2: f.data = sdo(`EOD_IX_MAP2, `EOD_SUB_CNT, 32'h0000_0000);
      4'h3: f.data = sdo(`EOD_IX_MAP2, `EOD_SUB_VAL,
                         {`EOD_IX_SPEED, `EOD_SUB_VAL,
                          `EOD_MAPLEN_16});
      4'h4: f.data = sdo(`EOD_IX_MAP2, `EOD_SUB_CNT,
                         {24'h00_0000, `EOD_MAP_MAX});
      4'h5: f.data = sdo(`EOD_IX_SPDCTL, `EOD_SUB_VAL,
                         32'h0000_0001);
      4'h6: f.data = sdo(`EOD_IX_STORE, `EOD_SUB_VAL, `EOD_SIG);
      default: begin
        f.id   = `EOD_ID_NMT;
        f.len  = `EOD_NMT_LEN;
        f.data = {48'h0000_0000_0000, `EOD_NMT_ALL,
                  `EOD_NMT_START};
      end
    endcase
    return f;
  endfunction : seq_frame

  always_comb begin
    n = s;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (lnk.d2m_valid) begin
      n.rxf = lnk.d2m_frame;
      n.rxcnt = s.rxcnt + 16'h1;
    end
    // a frame leaves only on the ready edge; the next one follows directly
    if (s.txv && lnk.m2d_ready) begin
      if (s.st == EOD_HSEQ && s.step != `EOD_SEQ_LAST) begin
        n.step = s.step + 4'h1;
        n.txf = seq_frame(n.step, s.node);
      end else begin
        n.txv = 1'b0;
        n.st = EOD_HIDLE;
      end
    end
    // no wait state: answer registered in the setup cycle
    if (psel && !penable) begin
      n.pready = 1'b1;
      case (paddr)
        `EOD_HR_CTRL:  n.prdata = '0;
        `EOD_HR_TXID:  n.prdata = {21'h00_0000, s.txf.id};
        `EOD_HR_TXLEN: n.prdata = {28'h000_0000, s.txf.len};
        `EOD_HR_TXLO:  n.prdata = s.txf.data[31:0];
        `EOD_HR_TXHI:  n.prdata = s.txf.data[63:32];
        `EOD_HR_RXID:  n.prdata = {21'h00_0000, s.rxf.id};
        `EOD_HR_RXLO:  n.prdata = s.rxf.data[31:0];
        `EOD_HR_RXHI:  n.prdata = s.rxf.data[63:32];
        `EOD_HR_STAT:  n.prdata = {s.rxcnt, 14'h0000,
                                   s.st == EOD_HSEQ, s.txv};
        `EOD_HR_NODE:  n.prdata = {25'h000_0000, s.node};
        default: begin
          n.prdata = '0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    // writes to the frame registers are dropped while a frame is out
    if (psel && penable && s.pready && pwrite && !s.txv) begin
      case (paddr)
        `EOD_HR_TXID:  n.txf.id = pwdata[10:0];
        `EOD_HR_TXLEN: n.txf.len = pwdata[3:0];
        `EOD_HR_TXLO:  n.txf.data[31:0] = pwdata;
        `EOD_HR_TXHI:  n.txf.data[63:32] = pwdata;
        `EOD_HR_NODE:  n.node = pwdata[6:0];
        `EOD_HR_CTRL: begin
          if (pwdata[1]) begin
            n.st = EOD_HSEQ;
            n.step = 4'h0;
            n.txf = seq_frame(4'h0, s.node);
            n.txv = 1'b1;
          end else if (pwdata[0]) begin
            n.txv = 1'b1;
          end
        end
        default: n.node = s.node;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s    <= '0;
      s.st <= EOD_HIDLE;
    end else begin
      s <= n;
    end
  end

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign lnk.m2d_valid = s.txv;
  assign lnk.m2d_frame = s.txf;
endmodule : eod_master

//--- testbench/eod_assertions.sv
// eod_assertions: link-level checks between master and device ends
// assumes: instantiated beside the eod_if that joins the two ends
`timescale 1ns/1ps
module eod_assertions
  import eod_pkg::*;
#(
  parameter logic [6:0] NODE = 7'h01
) (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // frame link
  input wire logic       m2d_valid,
  input wire logic       m2d_ready,
  input wire eod_frame_t m2d_frame,
  input wire logic       d2m_valid,
  input wire eod_frame_t d2m_frame
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // only node-addressed eight-byte requests earn a reply
  sequence sdo_take;
    m2d_valid && m2d_ready && m2d_frame.id == (11'h600 | {4'h0, NODE}) &&
      m2d_frame.len == 4'h8;
  endsequence
  sequence sdo_reply;
    d2m_valid && d2m_frame.id == (11'h580 | {4'h0, NODE});
  endsequence
  hold_frame_a: assert property (m2d_valid && !m2d_ready |=>
    m2d_valid && $stable(m2d_frame)) else $error("frame lost");
  ready_drop_a: assert property (sdo_take |=> !m2d_ready)
    else $error("ready kept after request");
  reply_soon_a: assert property (sdo_take |-> ##[1:12] sdo_reply)
    else $error("no reply to request");
  reply_len_a: assert property (sdo_reply |-> d2m_frame.len == 4'h8)
    else $error("reply length");
  reply_cmd_a: assert property (sdo_reply |-> d2m_frame.data[7:0]
    inside {8'h60, 8'h43, 8'h80}) else $error("reply command");
  abort_code_a: assert property (sdo_reply ##0 d2m_frame.data[7:0] ==
    8'h80 |-> d2m_frame.data[63:32] == 32'h0602_0000) else $error("abort");
  ready_back_a: assert property (sdo_reply |-> ##[0:1] m2d_ready)
    else $error("ready not back");
  nmt_quiet_a: assert property (m2d_valid && m2d_ready &&
    m2d_frame.id == 11'h000 |=> m2d_ready) else $error("nmt stalled");
  pos_len_a: assert property (d2m_valid && d2m_frame.id[10:7] == 4'h3
    |-> d2m_frame.len == 4'h4) else $error("position frame length");
  boot_load_a: assert property ($rose(presetn) |-> !m2d_ready [*3])
    else $error("ready during restore");
endmodule : eod_assertions

//--- testbench/test_encoder_process_object_dictionary.sv
// test_encoder_process_object_dictionary: both ends joined over eod_if
// assumes: package, interface and both ends compiled first; node 1
`timescale 1ns/1ps
module test_encoder_process_object_dictionary;
  import eod_pkg::*;
  typedef struct {logic [7:0] rq; logic [15:0] ix; logic [7:0] sb;
    logic [31:0] v; logic [7:0] rs; logic [31:0] hi;} eod_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, cam_enable;
  logic [31:0] pwdata = 32'h0, prdata, rdv, steps, preset;
  logic        pready, pslverr, operational, speed_enable;
  logic [31:0] span;
  logic signed [31:0] vel = 32'sh0001_0000;
  int          err_total = 0, num_checks = 0;
  eod_row_t    rows[17] = '{
    '{8'h22,16'h6001,8'h0,32'h1234,8'h60,0}, '{8'h40,16'h2101,8'h0,0,8'h43,32'h1234},
    '{8'h22,16'h6002,8'h0,32'h5678,8'h60,0}, '{8'h22,16'h6003,8'h0,32'h7,8'h60,0},
    '{8'h22,16'h6004,8'h0,32'h1,8'h80,0}, '{8'h40,16'h2000,8'h0,0,8'h43,32'h1234},
    '{8'h40,16'h6030,8'h1,0,8'h43,32'h0}, '{8'h22,16'h3010,8'h1,32'h1,8'h60,0},
    '{8'h40,16'h6030,8'h1,0,8'h43,32'h7FFF}, '{8'h40,16'h3010,8'h2,0,8'h43,32'h10000},
    '{8'h40,16'h6040,8'h0,0,8'h43,32'h1}, '{8'h22,16'h2200,8'h0,32'h32,8'h60,0},
    '{8'h40,16'h6200,8'h0,0,8'h43,32'h32}, '{8'h22,16'h6200,8'h0,32'h0,8'h80,0},
    '{8'h40,16'h6300,8'h1,0,8'h43,32'h4}, '{8'h22,16'h6301,8'h1,32'h1,8'h60,0},
    '{8'h40,16'h6300,8'h1,0,8'h43,32'h9}};
  eod_if lnk ();
  always #4 pclk = ~pclk;
  // speed starts past the 16-bit object's reach, later goes negative
  eod_device #(.CYC_PER_MS(10)) u_eod_device (.pclk(pclk), .presetn(presetn),
    .lnk(lnk.dev), .node_id(7'h01), .position_in(32'h0000_1234),
    .velocity_in(vel), .accel_in(16'h0005), .cam_in(8'h09),
    .steps_per_turn(steps), .total_step_range(span), .position_preset(preset),
    .cam_enable(cam_enable), .speed_enable(speed_enable),
    .operational(operational));
  eod_master u_eod_master (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.mst));
  eod_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .m2d_valid(lnk.m2d_valid), .m2d_ready(lnk.m2d_ready),
    .m2d_frame(lnk.m2d_frame), .d2m_valid(lnk.d2m_valid),
    .d2m_frame(lnk.d2m_frame));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, a);
    num_checks++;
    if (a !== e) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", nm, e, a);
    end
  endtask : chk
  task automatic wt(input int b);
    do apb(1'b0, 8'h20, 32'h0); while (rdv[b] !== 1'b0);
  endtask : wt
  task automatic xfer(input eod_row_t r);
    apb(1'b1, 8'h04, 32'h601); apb(1'b1, 8'h08, 32'h8);
    apb(1'b1, 8'h0C, {r.sb, r.ix, r.rq});
    apb(1'b1, 8'h10, r.v); apb(1'b1, 8'h00, 32'h1);
    wt(0);
    apb(1'b0, 8'h18, 32'h0);
    chk("reply cmd", {24'h0, r.rs}, {24'h0, rdv[7:0]});
    apb(1'b0, 8'h1C, 32'h0);
    if (r.rq == 8'h40) chk("reply value", r.hi, rdv);
  endtask : xfer
  task test_done;
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // rows, two restarts and two cyclic frames need about 2000 cycles
  initial begin
    #(8 * 30000);
    err_total++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge pclk);
    chk("steps", 32'h0001_0000, steps);
    chk("preset", 32'h0, preset);
    presetn <= 1'b1;
    apb(1'b1, 8'h24, 32'h1);
    foreach (rows[i]) xfer(rows[i]);
    vel <= 32'shFFFF_0000;
    xfer('{8'h40,16'h6030,8'h1,0,8'h43,32'hFFFF_8000});
    chk("steps", 32'h1234, steps);
    chk("preset", 32'h7, preset);
    chk("cam en", 32'h1, {24'h0, cam_enable});
    $display("row table done");
    apb(1'b1, 8'h00, 32'h2);
    wt(1);
    chk("oper", 32'h1, {31'h0, operational});
    chk("spd en", 32'h1, {31'h0, speed_enable});
    $display("setup sequence done");
    // mapped speed sits at the negative limit by now
    do apb(1'b0, 8'h14, 32'h0); while (rdv[10:0] !== 11'h181);
    apb(1'b0, 8'h18, 32'h0);
    chk("cyclic pos", 32'h1234, rdv);
    do apb(1'b0, 8'h14, 32'h0); while (rdv[10:0] !== 11'h281);
    apb(1'b0, 8'h18, 32'h0);
    chk("mapped spd", 32'h8000, rdv);
    $display("cyclic test done");
    // store survives reset, so saved values must come back
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("steps", 32'h1234, steps);
    chk("preset", 32'h7, preset);
    chk("oper", 32'h0, {31'h0, operational});
    chk("range", 32'h5678, span);
    chk("cam en", 32'h1, {24'h0, cam_enable});
    xfer('{8'h40,16'h6200,8'h0,0,8'h43,32'h32});
    $display("restore test done");
    test_done();
  end
endmodule : test_encoder_process_object_dictionary
